// *** design/cxc_consts.vh ***
// Constants for the codec transfer-count and event block.
// Assumes inclusion by the block's design files only.
`ifndef CXC_CONSTS_VH
`define CXC_CONSTS_VH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define CXC_CNT_W         16
`define CXC_FIFO_BYTES    7'h40
`define CXC_FIFO_PTR_W    7
`define CXC_ADPCM_BYTES   4
`define CXC_ACC_W         16
`define CXC_STEP_W        7
`define CXC_GAIN_W        6
`define CXC_SMP_W         16

// ----------------------------------------------------------------
// Timer tick
// ----------------------------------------------------------------
`define CXC_CLK_NS        5
`define CXC_TICK_NS       10000
`define CXC_TICK_CYC      (`CXC_TICK_NS / `CXC_CLK_NS)

// ----------------------------------------------------------------
// Full-scale codes
// ----------------------------------------------------------------
`define CXC_POS_FULL      16'h7fff
`define CXC_NEG_FULL      16'h8000

`endif

// *** design/cxc_mix_sat.v ***
// Loopback gain and saturating mixer for one output channel.
// Assumes signed 16-bit samples on the block clock.
`timescale 1ns/1ps
`include "cxc_consts.vh"

module cxc_mix_sat #(
  parameter SW = `CXC_SMP_W,
  parameter GW = `CXC_GAIN_W
) (
  input  wire [SW-1:0] i_play,
  input  wire [SW-1:0] i_loop,
  input  wire          i_loop_on,
  input  wire [GW-1:0] i_atten,
  output wire [SW-1:0] o_mix
);

  // ----------------------------------------------------------------
  // Attenuate and sum
  // ----------------------------------------------------------------
  wire signed [SW-1:0] loop_s = i_loop;
  wire signed [SW-1:0] att_s  = loop_s >>> (i_atten[3:0]);
  wire signed [SW:0]   sum_s  = {i_play[SW-1], i_play} +
                                (i_loop_on ? {att_s[SW-1], att_s} : {(SW+1){1'b0}});

  // Clip to full scale
  assign o_mix = (sum_s[SW] != sum_s[SW-1]) ?
                 (sum_s[SW] ? `CXC_NEG_FULL : `CXC_POS_FULL) : sum_s[SW-1:0];

endmodule // cxc_mix_sat

// *** design/cxc_core.v ***
// Transfer counting, ADPCM state control, timer, interrupt and loopback.
// Assumes synchronous strobes from host logic and FIFO logic on i_clk.
//
// Behaviour
// - ADPCM lets the FIFO fill to 64 bytes.
// - ADPCM counts one sample per four bytes; status shows byte index.
// - Enable low clears ADPCM accumulator and step; enable starts conversion.
// - Capture hold freezes adaptation after a whole 4-byte word.
// - Frozen capture stops requesting once the host drains the FIFO.
// - Playback underrun in ADPCM freezes adaptation until data returns.
// - Playback accumulator clear resets accumulator only, not step size.
// - Upper base write loads both base halves into current count.
// - DMA runs with enable set and CPU select clear; select changes need gate.
// - DMA samples count down; after zero, interrupt and reload from base.
// - Basic mode reloads the capture count from the playback base.
// - Count rollunder sets count flag and summary; status write clears.
// - Loopback routes ADC data into mixer; split gives separate gains.
// - Mono capture with stereo playback loops into both channels.
// - Mixer sum beyond full scale saturates to full-scale code.
// - Timer loads on enable, ticks 10 us, flags at zero, reloads.
// - Any count rollover sets summary until status write or flags cleared.
// - Interrupt gate low holds IRQ low; summary still tracks events.
// - Capture overrun keeps last whole sample; no overwrite during DMA.
// - Playback underrun repeats last sample unless zero-fill selected.
`timescale 1ns/1ps
`include "cxc_consts.vh"

module cxc_core #(
  parameter CW       = `CXC_CNT_W,
  parameter SW       = `CXC_SMP_W,
  parameter GW       = `CXC_GAIN_W,
  parameter TICK_CYC = `CXC_TICK_CYC
) (
  input  wire          i_clk,
  input  wire          i_rst_b,
  input  wire          i_ce,
  // Mode and control
  input  wire          i_ext_mode,
  input  wire          i_adpcm_play,
  input  wire          i_adpcm_cap,
  input  wire          i_playback_enable,
  input  wire          i_capture_enable,
  input  wire          i_mode_change_gate,
  input  wire          i_sel_wr,
  input  wire          i_sel_play_val,
  input  wire          i_sel_cap_val,
  input  wire          i_adpcm_capture_hold,
  input  wire          i_adpcm_play_acc_clear,
  input  wire          i_irq_gate,
  input  wire          i_play_zero_fill_sel,
  // Base and timer registers
  input  wire          i_play_base_lo_wr,
  input  wire          i_play_base_hi_wr,
  input  wire          i_cap_base_lo_wr,
  input  wire          i_cap_base_hi_wr,
  input  wire [7:0]    i_wdata,
  input  wire [CW-1:0] i_timer_value,
  input  wire          i_countdown_run,
  // Status writes
  input  wire          i_status_port_wr,
  input  wire          i_flag_wr,
  input  wire [4:0]    i_flag_wdata,
  // FIFO side
  input  wire          i_play_byte,
  input  wire          i_cap_byte,
  input  wire          i_play_fifo_empty,
  input  wire          i_cap_fifo_empty,
  input  wire [6:0]    i_cap_fifo_level,
  input  wire          i_adpcm_step,
  input  wire [CW-1:0] i_adpcm_delta,
  input  wire          i_sample_clk,
  input  wire          i_cap_full,
  input  wire          i_cap_new,
  input  wire          i_play_new,
  input  wire          i_dma_busy,
  input  wire          i_cap_stereo,
  input  wire          i_play_stereo,
  input  wire [SW-1:0] i_adc_l,
  input  wire [SW-1:0] i_adc_r,
  input  wire [SW-1:0] i_play_l,
  input  wire [SW-1:0] i_play_r,
  // Loopback
  input  wire          i_loop_route_on,
  input  wire          i_split_loop_gain,
  input  wire [GW-1:0] i_loop_gain_l,
  input  wire [GW-1:0] i_loop_gain_r,
  // Outputs
  output wire          o_play_dma_run,
  output wire          o_cap_dma_run,
  output wire          o_cap_req,
  output reg  [1:0]    o_byte_idx,
  output wire [6:0]    o_fifo_limit,
  output reg  [CW-1:0] o_play_count,
  output reg  [CW-1:0] o_cap_count,
  output reg           o_playback_count_flag,
  output reg           o_capture_count_flag,
  output reg           o_countdown_done_flag,
  output reg           o_play_starve_flag,
  output reg           o_cap_overrun_flag,
  output reg           o_irq_summary,
  output reg           o_irq,
  output reg           o_playback_cpu_transfer_sel,
  output reg           o_capture_cpu_transfer_sel,
  output reg  [CW-1:0] o_cap_acc,
  output reg  [6:0]    o_cap_step,
  output reg  [CW-1:0] o_play_acc,
  output reg  [6:0]    o_play_step,
  output reg  [SW-1:0] o_cap_sample,
  output reg  [SW-1:0] o_dac_l,
  output reg  [SW-1:0] o_dac_r
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function [6:0] step_next;
    input [6:0] s;
    begin
      step_next = (s == 7'h58) ? s : s + 7'h01;
    end
  endfunction

  localparam [1:0] ST_RUN  = 2'b01;
  localparam [1:0] ST_HOLD = 2'b10;

  localparam TW = 14;

  reg  [7:0]    play_lo_q;
  reg  [7:0]    play_hi_q;
  reg  [7:0]    cap_lo_q;
  reg  [7:0]    cap_hi_q;
  reg  [CW-1:0] tmr_q;
  reg  [TW-1:0] tick_q;
  reg           tmr_run_q;
  reg  [1:0]    pbyte_q;
  reg  [1:0]    cbyte_q;
  reg  [1:0]    cst_q;
  reg           pfrz_q;
  reg  [SW-1:0] hold_l_q;
  reg  [SW-1:0] hold_r_q;
  reg           starve_q;

  wire [CW-1:0] play_base = {play_hi_q, play_lo_q};
  wire [CW-1:0] cap_base  = i_ext_mode ? {cap_hi_q, cap_lo_q} : play_base;

  // ----------------------------------------------------------------
  // DMA gating
  // ----------------------------------------------------------------
  assign o_play_dma_run = i_playback_enable & ~o_playback_cpu_transfer_sel;
  assign o_cap_dma_run  = i_capture_enable & ~o_capture_cpu_transfer_sel;
  assign o_fifo_limit   = `CXC_FIFO_BYTES;
  assign o_cap_req      = o_cap_dma_run & ~i_cap_fifo_empty &
                          ~(cst_q == ST_HOLD && i_cap_fifo_level == 7'h00);

  // Sample boundary per direction; ADPCM counts per 4-byte word
  wire play_smp = i_play_byte & o_play_dma_run & (~i_adpcm_play | (pbyte_q == 2'h3));
  wire cap_smp  = i_cap_byte & o_cap_dma_run & (~i_adpcm_cap | (cbyte_q == 2'h3));
  wire cap_word = i_cap_byte & (cbyte_q == 2'h3);

  wire tick     = (tick_q == TICK_CYC[TW-1:0] - 14'h0001);
  wire tmr_ev   = tmr_run_q & tick & (tmr_q == {CW{1'b0}});
  wire play_ev  = play_smp & (o_play_count == {CW{1'b0}});
  wire cap_ev   = cap_smp & (o_cap_count == {CW{1'b0}});
  wire p_keep   = o_playback_count_flag & ~i_status_port_wr & ~(i_flag_wr & ~i_flag_wdata[0]);
  wire c_keep   = o_capture_count_flag & ~i_status_port_wr & ~(i_flag_wr & ~i_flag_wdata[1]);
  wire t_keep   = o_countdown_done_flag & ~i_status_port_wr & ~(i_flag_wr & ~i_flag_wdata[2]);

  // ----------------------------------------------------------------
  // Registers, counts and flags
  // ----------------------------------------------------------------
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      play_lo_q <= 8'h00;
      play_hi_q <= 8'h00;
      cap_lo_q <= 8'h00;
      cap_hi_q <= 8'h00;
      o_play_count <= 16'h0000;
      o_cap_count <= 16'h0000;
      tmr_q <= 16'h0000;
      tick_q <= 14'h0000;
      tmr_run_q <= 1'b0;
      pbyte_q <= 2'h0;
      cbyte_q <= 2'h0;
      o_byte_idx <= 2'h0;
      o_playback_cpu_transfer_sel <= 1'b0;
      o_capture_cpu_transfer_sel <= 1'b0;
      o_playback_count_flag <= 1'b0;
      o_capture_count_flag <= 1'b0;
      o_countdown_done_flag <= 1'b0;
      o_play_starve_flag <= 1'b0;
      o_cap_overrun_flag <= 1'b0;
      o_irq_summary <= 1'b0;
      o_irq <= 1'b0;
    end else if (i_ce) begin
      if (i_sel_wr && i_mode_change_gate) begin
        o_playback_cpu_transfer_sel <= i_sel_play_val;
        o_capture_cpu_transfer_sel <= i_sel_cap_val;
      end
      if (i_play_base_lo_wr)
        play_lo_q <= i_wdata;
      if (i_cap_base_lo_wr)
        cap_lo_q <= i_wdata;
      if (i_play_byte)
        pbyte_q <= pbyte_q + 2'h1;
      if (i_cap_byte)
        cbyte_q <= cbyte_q + 2'h1;
      o_byte_idx <= o_playback_cpu_transfer_sel ? pbyte_q : cbyte_q;
      // Playback count
      if (i_play_base_hi_wr) begin
        play_hi_q <= i_wdata;
        o_play_count <= {i_wdata, play_lo_q};
      end else if (play_ev)
        o_play_count <= play_base;
      else if (play_smp)
        o_play_count <= o_play_count - 16'h0001;
      // Capture count
      if (i_cap_base_hi_wr) begin
        cap_hi_q <= i_wdata;
        o_cap_count <= {i_wdata, cap_lo_q};
      end else if (cap_ev)
        o_cap_count <= cap_base;
      else if (cap_smp)
        o_cap_count <= o_cap_count - 16'h0001;
      // Timer
      tmr_run_q <= i_countdown_run;
      tick_q <= tick ? 14'h0000 : tick_q + 14'h0001;
      if (i_countdown_run && !tmr_run_q)
        tmr_q <= i_timer_value;
      else if (tmr_run_q && tick)
        tmr_q <= (tmr_q == {CW{1'b0}}) ? i_timer_value : tmr_q - 16'h0001;
      // Count flags: set wins over clear
      o_playback_count_flag <= play_ev | p_keep;
      o_capture_count_flag <= cap_ev | c_keep;
      o_countdown_done_flag <= tmr_ev | t_keep;
      o_irq_summary <= play_ev | cap_ev | tmr_ev |
        (o_irq_summary & (p_keep | c_keep | t_keep));
      o_irq <= i_irq_gate & (play_ev | cap_ev | tmr_ev | o_irq_summary);
      // Error flags
      o_play_starve_flag <= starve_q |
        (o_play_starve_flag & ~(i_flag_wr & ~i_flag_wdata[3] & ~i_play_fifo_empty));
      o_cap_overrun_flag <= (i_cap_full & i_cap_new) |
        (o_cap_overrun_flag & ~(i_flag_wr & ~i_flag_wdata[4] & ~i_cap_full));
    end
  end

  // ----------------------------------------------------------------
  // ADPCM capture state
  // ----------------------------------------------------------------
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cap_acc <= 16'h0000;
      o_cap_step <= 7'h00;
      cst_q <= ST_RUN;
    end else if (i_ce) begin
      if (!i_capture_enable) begin
        o_cap_acc <= 16'h0000;
        o_cap_step <= 7'h00;
        cst_q <= ST_RUN;
      end else begin
        case (cst_q)
          ST_RUN: begin
            if (i_adpcm_step) begin
              o_cap_acc <= o_cap_acc + i_adpcm_delta;
              o_cap_step <= step_next(o_cap_step);
            end
            if (i_adpcm_capture_hold && cap_word)
              cst_q <= ST_HOLD;
          end
          ST_HOLD: begin
            if (!i_adpcm_capture_hold)
              cst_q <= ST_RUN;
          end
          default: cst_q <= ST_RUN;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // ADPCM playback state
  // ----------------------------------------------------------------
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_play_acc <= 16'h0000;
      o_play_step <= 7'h00;
      pfrz_q <= 1'b0;
    end else if (i_ce) begin
      if (!i_playback_enable) begin
        o_play_acc <= 16'h0000;
        o_play_step <= 7'h00;
        pfrz_q <= 1'b0;
      end else begin
        if (i_adpcm_play && starve_q)
          pfrz_q <= 1'b1;
        else if (i_play_new)
          pfrz_q <= 1'b0;
        if (i_adpcm_play_acc_clear)
          o_play_acc <= 16'h0000;
        else if (i_adpcm_step && !pfrz_q)
          o_play_acc <= o_play_acc + i_adpcm_delta;
        if (i_adpcm_step && !pfrz_q)
          o_play_step <= step_next(o_play_step);
      end
    end
  end

  // ----------------------------------------------------------------
  // Sample path: overrun, underrun, loopback
  // ----------------------------------------------------------------
  wire [SW-1:0] loop_r = i_cap_stereo ? i_adc_r : i_adc_l;
  wire [GW-1:0] gain_r = i_split_loop_gain ? i_loop_gain_r : i_loop_gain_l;
  wire [SW-1:0] src_l  = starve_q ? (i_play_zero_fill_sel ? {SW{1'b0}} : hold_l_q) : i_play_l;
  wire [SW-1:0] src_r0 = starve_q ? (i_play_zero_fill_sel ? {SW{1'b0}} : hold_r_q) : i_play_r;
  wire [SW-1:0] src_r  = i_play_stereo ? src_r0 : src_l;
  wire [SW-1:0] mix_l;
  wire [SW-1:0] mix_r;

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cap_sample <= 16'h0000;
      hold_l_q <= 16'h0000;
      hold_r_q <= 16'h0000;
      starve_q <= 1'b0;
      o_dac_l <= 16'h0000;
      o_dac_r <= 16'h0000;
    end else if (i_ce) begin
      if (i_cap_new && !i_cap_full && !i_dma_busy)
        o_cap_sample <= i_adc_l;
      if (i_sample_clk) begin
        starve_q <= i_play_fifo_empty & i_playback_enable;
        if (!starve_q) begin
          hold_l_q <= i_play_l;
          hold_r_q <= i_play_r;
        end
        o_dac_l <= mix_l;
        o_dac_r <= mix_r;
      end
    end
  end

  cxc_mix_sat #(.SW(SW), .GW(GW)) u_mix_l (
    .i_play    (src_l),
    .i_loop    (i_adc_l),
    .i_loop_on (i_loop_route_on),
    .i_atten   (i_loop_gain_l),
    .o_mix     (mix_l)
  );

  cxc_mix_sat #(.SW(SW), .GW(GW)) u_mix_r (
    .i_play    (src_r),
    .i_loop    (loop_r),
    .i_loop_on (i_loop_route_on),
    .i_atten   (gain_r),
    .o_mix     (mix_r)
  );

endmodule // cxc_core

// *** verif/cxc_host_model.sv ***
// Host DMA model: sends a burst of playback bytes, fast or paced.
// Assumes the block's playback run level gates every byte it sends.
`timescale 1ns/1ps
module cxc_host_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_run,
  input  wire logic       i_go,
  input  wire logic [7:0] i_n,
  input  wire logic [3:0] i_gap,
  output logic            o_byte,
  output logic            o_busy
);
  logic [7:0] left_q;
  logic [3:0] wait_q;
  // --------------------------------------------------------------
  // Byte pacing
  // --------------------------------------------------------------
  assign o_busy = (left_q != 8'h00) || o_byte;
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      {left_q, wait_q, o_byte} <= 13'h0;
    end else if (i_go) begin
      left_q <= i_n;
      o_byte <= 1'b0;
    end else if (left_q != 8'h00 && i_run && wait_q == 4'h0) begin
      {left_q, wait_q, o_byte} <= {left_q - 8'h01, i_gap, 1'b1};
    end else begin
      wait_q <= (wait_q != 4'h0) ? wait_q - 4'h1 : 4'h0;
      o_byte <= 1'b0;
    end
  end
endmodule // cxc_host_model

// *** verif/cxc_core_properties.sv ***
// Port-level checks for the transfer-count block.
// Assumes it is bound onto cxc_core with i_ce held high.
`timescale 1ns/1ps
module cxc_core_properties (
  input wire logic        i_clk, i_rst_b, i_ext_mode, i_adpcm_play, i_playback_enable,
  input wire logic        i_capture_enable, i_mode_change_gate, i_adpcm_play_acc_clear,
  input wire logic        i_irq_gate, i_play_base_hi_wr, i_countdown_run, i_status_port_wr,
  input wire logic        i_flag_wr, i_play_byte, i_cap_byte, i_adpcm_step, i_cap_full,
  input wire logic [7:0]  i_wdata,
  input wire logic        o_play_dma_run, o_cap_dma_run, o_playback_count_flag,
  input wire logic        o_capture_count_flag, o_cap_overrun_flag, o_irq_summary, o_irq,
  input wire logic        o_playback_cpu_transfer_sel, o_capture_cpu_transfer_sel,
  input wire logic [6:0]  o_fifo_limit, o_cap_step, o_play_step,
  input wire logic [15:0] o_play_count, o_cap_acc, o_play_acc
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // --------------------------------------------------------------
  // Sequences and checks
  // --------------------------------------------------------------
  sequence play_smp;
    i_ext_mode && !i_adpcm_play && o_play_dma_run && i_play_byte && !i_play_base_hi_wr;
  endsequence
  sequence clr_req;
    i_status_port_wr && !i_play_byte && !i_cap_byte && !i_countdown_run && !$past(i_countdown_run);
  endsequence
  chk_fifo_depth: assert property (o_fifo_limit == 7'h40)
    else $error("fifo limit not 64 bytes");
  chk_cap_cleared: assert property (!i_capture_enable |=> o_cap_acc == 16'h0 && o_cap_step == 7'h0)
    else $error("capture state not cleared");
  chk_acc_only: assert property (i_adpcm_play_acc_clear && i_playback_enable && !i_adpcm_step
    |=> o_play_acc == 16'h0 && $stable(o_play_step)) else $error("acc clear wrong");
  chk_base_load: assert property (i_play_base_hi_wr && !i_play_byte && !i_cap_byte
    |=> o_play_count[15:8] == $past(i_wdata)) else $error("count not loaded");
  chk_dma_gate: assert property (o_play_dma_run == (i_playback_enable && !o_playback_cpu_transfer_sel)
    && o_cap_dma_run == (i_capture_enable && !o_capture_cpu_transfer_sel))
    else $error("dma run level wrong");
  chk_sel_locked: assert property (!i_mode_change_gate |=> $stable(o_playback_cpu_transfer_sel)
    && $stable(o_capture_cpu_transfer_sel)) else $error("select changed");
  chk_count_step: assert property (play_smp ##0 (o_play_count != 16'h0)
    |=> o_play_count == $past(o_play_count) - 16'h1) else $error("no decrement");
  chk_roll_flag: assert property (play_smp ##0 (o_play_count == 16'h0)
    |=> o_playback_count_flag && o_irq_summary) else $error("no rollunder flag");
  chk_status_clr: assert property (clr_req |=> !o_playback_count_flag && !o_capture_count_flag
    && !o_irq_summary) else $error("status write kept flags");
  chk_flag_summ: assert property ($rose(o_playback_count_flag) || $rose(o_capture_count_flag)
    |-> o_irq_summary) else $error("summary not set");
  chk_summ_hold: assert property (o_irq_summary && !i_status_port_wr && !i_flag_wr
    |=> o_irq_summary) else $error("summary dropped");
  chk_irq_masked: assert property ((!i_irq_gate) [*2] |-> !o_irq)
    else $error("irq while gated");
  chk_overrun_kept: assert property (o_cap_overrun_flag && i_cap_full && i_flag_wr
    |=> o_cap_overrun_flag) else $error("overrun cleared early");
endmodule // cxc_core_properties

bind cxc_core cxc_core_properties u_cxc_core_properties (.*);

// *** verif/test_codec_transfer_count_irq.sv ***
// Self-checking bench for counts, timer, interrupt summary and loopback.
// Assumes a shortened timer tick and the host model on playback bytes.
`timescale 1ns/1ps
module test_codec_transfer_count_irq;
  logic i_clk = 1'b0;
  logic i_rst_b, i_ce, i_ext_mode, i_adpcm_play, i_adpcm_cap, i_playback_enable;
  logic i_capture_enable, i_mode_change_gate, i_sel_wr, i_sel_play_val, i_sel_cap_val;
  logic i_adpcm_capture_hold, i_adpcm_play_acc_clear, i_irq_gate, i_play_zero_fill_sel;
  logic i_play_base_lo_wr, i_play_base_hi_wr, i_cap_base_lo_wr, i_cap_base_hi_wr;
  logic i_countdown_run, i_status_port_wr, i_flag_wr, i_play_byte, i_cap_byte;
  logic i_play_fifo_empty, i_cap_fifo_empty, i_adpcm_step, i_sample_clk, i_cap_full;
  logic i_cap_new, i_play_new, i_dma_busy, i_cap_stereo, i_play_stereo, i_loop_route_on;
  logic i_split_loop_gain, h_go, h_busy, o_play_dma_run, o_cap_dma_run, o_cap_req, o_irq;
  logic o_playback_count_flag, o_capture_count_flag, o_countdown_done_flag, o_irq_summary;
  logic o_play_starve_flag, o_cap_overrun_flag;
  logic o_playback_cpu_transfer_sel, o_capture_cpu_transfer_sel;
  logic [7:0] i_wdata, h_n;
  logic [4:0] i_flag_wdata;
  logic [3:0] h_gap;
  logic [1:0] o_byte_idx;
  logic [6:0] i_cap_fifo_level, o_fifo_limit, o_cap_step, o_play_step;
  logic [5:0] i_loop_gain_l, i_loop_gain_r;
  logic [15:0] i_timer_value, i_adpcm_delta, i_adc_l, i_adc_r, i_play_l, i_play_r;
  logic [15:0] o_play_count, o_cap_count, o_cap_acc, o_play_acc, o_cap_sample, o_dac_l, o_dac_r;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  cxc_core #(.TICK_CYC(4)) u_cxc_core (.*);
  cxc_host_model u_cxc_host_model (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_run(o_play_dma_run),
    .i_go(h_go), .i_n(h_n), .i_gap(h_gap), .o_byte(i_play_byte), .o_busy(h_busy));
  always #2.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end
  // --------------------------------------------------------------
  // Tasks and models
  // --------------------------------------------------------------
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask
  task automatic drive(input bit rnd);
    {i_ext_mode, i_adpcm_play, i_adpcm_cap, i_playback_enable, i_capture_enable,
     i_mode_change_gate, i_sel_wr, i_sel_play_val, i_sel_cap_val, i_adpcm_capture_hold,
     i_adpcm_play_acc_clear, i_irq_gate, i_play_zero_fill_sel, i_play_base_lo_wr,
     i_play_base_hi_wr, i_cap_base_lo_wr, i_cap_base_hi_wr, i_countdown_run, i_status_port_wr,
     i_flag_wr, i_cap_byte, i_play_fifo_empty, i_cap_fifo_empty, i_adpcm_step, i_sample_clk,
     i_cap_full, i_cap_new, i_play_new, i_dma_busy, i_cap_stereo, i_play_stereo,
     i_loop_route_on, i_split_loop_gain} = rnd ? 33'({$urandom, $urandom}) : 33'h0;
    {i_wdata, i_timer_value, i_flag_wdata, i_cap_fifo_level, i_adpcm_delta, i_adc_l, i_adc_r,
     i_play_l, i_play_r, i_loop_gain_l, i_loop_gain_r} =
      rnd ? 128'({$urandom, $urandom, $urandom, $urandom}) : 128'h0;
  endtask
  task automatic set_base(input logic [15:0] v, input logic cap);
    i_wdata = v[7:0];
    if (cap) pulse(i_cap_base_lo_wr); else pulse(i_play_base_lo_wr);
    i_wdata = v[15:8];
    if (cap) pulse(i_cap_base_hi_wr); else pulse(i_play_base_hi_wr);
  endtask
  task automatic play(input int n, input logic [3:0] gap);
    {h_n, h_gap, h_go} = {8'(n), gap, 1'b1};
    cyc(1);
    h_go = 1'b0;
    for (int k = 0; k < 600 && h_busy !== 1'b0; k++) cyc(1);
  endtask
  function automatic logic [16:0] cnt_model(input logic [15:0] b, input int n);
    logic [16:0] r;
    r = {1'b0, b};
    repeat (n) r = (r[15:0] == 16'h0) ? {1'b1, b} : {r[16], r[15:0] - 16'h1};
    return r;
  endfunction
  function automatic logic [15:0] mix(input logic [15:0] p, a, input logic [5:0] g);
    logic signed [16:0] s;
    s = $signed({p[15], p}) + ($signed({a[15], a}) >>> g[3:0]);
    return (s > 17'sh07fff) ? 16'h7fff : (s < -17'sh08000) ? 16'h8000 : s[15:0];
  endfunction
  // --------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------
  initial begin
    logic [16:0] e;
    logic [15:0] b;
    int n;
    void'($urandom(32'h3291));
    {i_rst_b, i_ce, h_go, h_n, h_gap} = {2'b01, 13'h0};
    drive(0);
    repeat (10) @(posedge i_clk);
    #1 i_rst_b = 1'b1;
    chk(16'({o_fifo_limit, o_irq_summary}), 16'h80);
    {i_ext_mode, i_adpcm_play, i_playback_enable} = 3'b111;
    set_base(16'h0001, 1'b0);
    chk(o_play_count, 16'h0001);
    play(8, 4'h0);
    chk(16'({o_play_count, o_playback_count_flag, o_irq_summary, o_irq}), 16'he);
    pulse(i_status_port_wr);
    chk(16'({o_playback_count_flag, o_irq_summary}), 16'h0);
    $display("test adpcm count done");
    i_adpcm_play = 1'b0;
    for (int t = 0; t < 5; t++) begin
      b = (t == 0) ? 16'h0000 : 16'($urandom_range(0, 15));
      n = $urandom_range(1, 40);
      i_irq_gate = 1'($urandom);
      set_base(b, 1'b0);
      play(n, 4'($urandom_range(0, 3)));
      cyc(1);
      e = cnt_model(b, n);
      chk(o_play_count, e[15:0]);
      chk(16'({o_playback_count_flag, o_irq_summary, o_irq}), 16'({e[16], e[16], e[16] & i_irq_gate}));
      if (n[0]) pulse(i_status_port_wr); else pulse(i_flag_wr);
      chk(16'({o_playback_count_flag, o_irq_summary}), 16'h0);
    end
    $display("test linear count done");
    {i_ext_mode, i_capture_enable} = 2'b01;
    set_base(16'h0003, 1'b0);
    repeat (4) pulse(i_cap_byte);
    chk(16'({o_play_count, o_irq_summary}), 16'h7);
    pulse(i_status_port_wr);
    i_ext_mode = 1'b1;
    set_base(16'h0002, 1'b1);
    repeat (3) pulse(i_cap_byte);
    chk(o_play_count, 16'h0003);
    chk(16'({o_cap_count, o_capture_count_flag, o_cap_req, o_byte_idx}), 16'h2f);
    $display("test capture count done");
    {i_sel_play_val, i_sel_cap_val} = 2'b11;
    pulse(i_sel_wr);
    chk(16'({o_playback_cpu_transfer_sel, o_play_dma_run}), 16'h1);
    i_mode_change_gate = 1'b1;
    pulse(i_sel_wr);
    chk(16'({o_playback_cpu_transfer_sel, o_cap_dma_run, o_play_dma_run}), 16'h4);
    {i_sel_play_val, i_sel_cap_val} = 2'b00;
    pulse(i_sel_wr);
    i_mode_change_gate = 1'b0;
    $display("test transfer select done");
    pulse(i_status_port_wr);
    {i_timer_value, i_countdown_run} = {16'h0003, 1'b1};
    cyc(6);
    chk(16'(o_countdown_done_flag), 16'h0);
    for (n = 0; n < 40 && o_countdown_done_flag !== 1'b1; n++) cyc(1);
    chk(16'({o_countdown_done_flag, o_irq_summary}), 16'h3);
    i_countdown_run = 1'b0;
    pulse(i_flag_wr);
    chk(16'({o_countdown_done_flag, o_irq_summary}), 16'h0);
    $display("test timer done");
    i_capture_enable = 1'b0;
    cyc(1);
    chk(16'({o_cap_acc, o_cap_step}), 16'h0);
    {i_capture_enable, i_adpcm_play, i_adpcm_delta} = {2'b11, 16'h0123};
    pulse(i_adpcm_step);
    chk(16'(o_play_step), 16'h1);
    pulse(i_adpcm_play_acc_clear);
    chk(o_play_acc, 16'h0);
    chk(16'(o_play_step), 16'h1);
    $display("test adpcm state done");
    {i_loop_route_on, i_cap_stereo, i_play_stereo} = 3'b111;
    for (int t = 0; t < 8; t++) begin
      {i_adc_l, i_adc_r, i_play_l, i_play_r} = {$urandom, $urandom};
      if (t < 2) {i_adc_l, i_adc_r, i_play_l, i_play_r} = {4{(t == 0) ? 16'h7fff : 16'h8000}};
      i_loop_gain_l = (t < 2) ? 6'h0 : 6'($urandom_range(0, 15));
      i_loop_gain_r = 6'($urandom_range(0, 15));
      i_split_loop_gain = 1'($urandom);
      i_cap_stereo = (t != 7);
      pulse(i_sample_clk);
      chk(o_dac_l, mix(i_play_l, i_adc_l, i_loop_gain_l));
      chk(o_dac_r, mix(i_play_r, i_cap_stereo ? i_adc_r : i_adc_l,
        i_split_loop_gain ? i_loop_gain_r : i_loop_gain_l));
    end
    $display("test loopback done");
    repeat (300) begin
      drive(1);
      cyc(1);
    end
    drive(0);
    i_rst_b = 1'b0;
    cyc(2);
    i_rst_b = 1'b1;
    cyc(2);
    chk(16'({o_play_count, o_irq_summary}), 16'h0);
    $display("test random soak done");
    close_out();
  end
endmodule // test_codec_transfer_count_irq
